// [hw/pmt_timer.sv]
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
// Notes on behaviour
// - input channel captures counter on rising edge; output channel acts on match.
// - channel writes ignored in capture mode; channels reset to zero.
// - accumulator A is accum8_three over accum8_two, counting pin seven.
// - accumulator A event counting runs whether or not the main timer is enabled.
// - A disabled: edge flag off, 8-bit enables apply; enabled: reverse.
// - event mode counts falling edges with select 0, rising with 1.
// - gated mode counts divide-by-64 ticks during gate; trailing edge sets flag.
// - divide-by-64 tick exists only while the main timer is enabled.
// - clock select picks prescaler, accumulator clock, /256 or /65536.
// - A disabled forces prescaler clock; select changes act at once.
// - overflow and edge flags request interrupts through their enables.
// - A overflow flag sets on high byte wrap; write 1 to bit 1 clears.
// - edge flag sets on counted or trailing edge; write 1 to bit 0 clears.
// - with fast clear, any accumulator A count access clears its flags.
// - accumulator B is accum8_one over accum8_zero; high wrap sets B overflow.
// - down-counter interrupt enable gates the underflow flag.
// - single-shot stops at zero; reload mode reloads the load value.
// - count reads return live count, or load value when readback set.
// - force latch copies channels 0-3 and accumulators, clears accumulators.
// - force load copies load value and resets prescaler, only while enabled.
// - disabled down-counter is held at all ones.
// - prescaler divides by 1, 4, 8 or 16, taken at next count load.
// - underflow flag sets on reaching zero, clears by writing 1.
// - latching needs both buffer enable and latch select.
module pmt_timer
  import pmt_pkg::*;
#(
  parameter int NCH = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire pmt_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NCH-1:0] timer_pin_i,
  output logic [NCH-1:0] compare_o,
  output logic accum_a_irq_o,
  output logic accum_b_irq_o,
  output logic downcount_irq_o
);

  if (NCH != 8) begin : g_check
    $error("pmt_timer serves exactly eight channels");
  end

  logic [NCH-1:0] pin_q;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  logic req;
  logic acc;
  logic wr_lo;
  logic wr_hi;
  logic wr_word;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic [31:0] rdata;
  logic [7:0] timer_ctl;
  logic [NCH-1:0] channel_direction_select;
  logic [7:0] acc_a_ctl;
  logic [7:0] acc_b_ctl;
  logic [7:0] acc_en;
  logic [7:0] ic_sys;
  logic main_timer_enable;
  logic fast_flag_clear;
  logic accum_a_system_enable;
  logic accum_mode_select;
  logic accum_edge_select;
  logic accum_b_system_enable;
  logic capture_latch_mode;
  logic [5:0] div64_cnt;
  logic div64_tick;
  logic accum_pin_edge;
  logic accum_gate;
  logic accumulator_clock;
  logic [15:0] main_cnt;
  logic main_tick;
  pmt_clk_sel_t clk_sel;
  logic [15:0] ch [NCH];
  logic [15:0] hold_ch [4];
  logic [7:0] hold_acc [4];
  logic [7:0] acc_count [4];
  logic [7:0] acc_load_data [4];
  logic [3:0] acc_load;
  logic [3:0] acc_inc;
  logic [3:0] acc_wrap;
  logic latch_evt;
  logic accum_a_overflow_flag;
  logic accum_input_edge_flag;
  logic accum_b_overflow_flag;
  logic fast_clr_a;
  logic fast_clr_b;
  logic downcount_irq_enable;
  logic reload_mode;
  logic load_readback_select;
  logic downcounter_enable;
  logic [1:0] dc_presc_sel;
  logic [1:0] dc_active_sel;
  logic [3:0] dc_presc_cnt;
  logic dc_presc_tick;
  logic [15:0] dc_load;
  logic [15:0] downcount_count_register;
  logic dc_count_write;
  logic force_count_load;
  logic force_capture_latch;
  logic dc_underflow_evt;
  logic downcount_underflow_flag;

  // Bus decode: one access per transfer, in the cycle that carries ack
  assign req = wb_req_i.cyc & wb_req_i.stb;
  assign acc = req & wb_ack_o;
  assign idx = wb_req_i.adr[9:2];
  assign wdat = wb_req_i.dat[7:0];
  assign wr_lo = acc & wb_req_i.we & wb_req_i.sel[0];
  assign wr_hi = acc & wb_req_i.we & wb_req_i.sel[1];
  assign wr_word = wr_lo & wb_req_i.sel[1];

  // Field views of control registers
  assign main_timer_enable = timer_ctl[BIT_TEN];
  assign fast_flag_clear = timer_ctl[BIT_FFC];
  assign accum_a_system_enable = acc_a_ctl[BIT_ACCUM_A_SYSTEM_ENABLE];
  assign accum_mode_select = acc_a_ctl[BIT_ACCUM_MODE_SELECT];
  assign accum_edge_select = acc_a_ctl[BIT_ACCUM_EDGE_SELECT];
  assign accum_b_system_enable = acc_b_ctl[BIT_ACCUM_B_SYSTEM_ENABLE];
  assign capture_latch_mode = ic_sys[BIT_CAPTURE_BUFFER_ENABLE] & ic_sys[BIT_LATCH_OR_QUEUE_SELECT];

  // Pin edge detection against the previous sample
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_q <= '0;
    end else begin
      pin_q <= timer_pin_i;
    end
  end
  assign rise = timer_pin_i & ~pin_q;
  assign fall = ~timer_pin_i & pin_q;

  // Software control registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_ctl <= CTL_RESET;
      channel_direction_select <= '0;
      acc_a_ctl <= CTL_RESET;
      acc_b_ctl <= CTL_RESET;
      acc_en <= CTL_RESET;
      ic_sys <= CTL_RESET;
    end else if (wr_lo) begin
      if (idx == IDX_TIMER_CTL) timer_ctl <= wdat & TIMER_CTL_MASK;
      if (idx == IDX_DIR) channel_direction_select <= wdat[NCH-1:0];
      if (idx == IDX_ACC_A_CTL) acc_a_ctl <= wdat;
      if (idx == IDX_ACC_B_CTL) acc_b_ctl <= wdat & ACC_B_CTL_MASK;
      if (idx == IDX_ACC_EN) acc_en <= wdat & ACC_EN_MASK;
      if (idx == IDX_IC_SYS) ic_sys <= wdat & IC_SYS_MASK;
    end
  end

  // Divide-by-64 tick from the main prescaler, stopped with the timer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div64_cnt <= DIV64_RESET;
    end else if (!main_timer_enable) begin
      div64_cnt <= DIV64_RESET;
    end else begin
      div64_cnt <= div64_cnt + 1'b1;
    end
  end
  assign div64_tick = main_timer_enable & (&div64_cnt);

  // Pin seven: the counted edge equals the trailing gate edge for either polarity
  assign accum_pin_edge = accum_edge_select ? rise[7] : fall[7];
  assign accum_gate = accum_edge_select ? ~timer_pin_i[7] : timer_pin_i[7];
  assign accumulator_clock = accum_mode_select ? (div64_tick & accum_gate)
                                               : accum_pin_edge;

  // Accumulator increments; A event counting ignores the main timer enable
  assign acc_inc[2] = accum_a_system_enable ? accumulator_clock
                                            : (acc_en[2] & rise[2]);
  assign acc_inc[3] = accum_a_system_enable ? acc_wrap[2]
                                            : (acc_en[3] & rise[3]);
  assign acc_inc[0] = accum_b_system_enable ? rise[0] : (acc_en[0] & rise[0]);
  assign acc_inc[1] = accum_b_system_enable ? acc_wrap[0]
                                            : (acc_en[1] & rise[1]);

  // Byte loads, or both bytes of a pair in one word write
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      acc_load[k] = wr_lo & (idx == 8'(IDX_CNT3 + 3 - k));
      acc_load_data[k] = wdat;
      if (wr_word && idx == ((k >= 2) ? IDX_ACC_A_WORD : IDX_ACC_B_WORD)) begin
        acc_load[k] = 1'b1;
        acc_load_data[k] = (k % 2 == 1) ? wb_req_i.dat[15:8] : wdat;
      end
    end
  end

  for (genvar k = 0; k < 4; k++) begin : g_acc
    pmt_accum8 #(
      .W(8)
    ) u_acc (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(latch_evt),
      .load_i(acc_load[k]),
      .load_data_i(acc_load_data[k]),
      .inc_i(acc_inc[k]),
      .count_o(acc_count[k]),
      .wrap_o(acc_wrap[k])
    );
  end

  // Main counter clock source
  assign clk_sel = accum_a_system_enable
                 ? pmt_clk_sel_t'({acc_a_ctl[BIT_COUNTER_CLOCK_SELECT_HI], acc_a_ctl[BIT_COUNTER_CLOCK_SELECT_LO]})
                 : PMT_CS_PRESCALER;
  always_comb begin
    unique case (clk_sel)
      PMT_CS_PRESCALER: main_tick = main_timer_enable;
      PMT_CS_ACCUM: main_tick = main_timer_enable & acc_inc[2];
      PMT_CS_DIV256: main_tick = main_timer_enable & acc_wrap[2];
      PMT_CS_DIV65536: main_tick = main_timer_enable & acc_wrap[3];
    endcase
  end

  // Free-running counter
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      main_cnt <= CH_RESET;
    end else if (main_tick) begin
      main_cnt <= main_cnt + 1'b1;
    end
  end

  // Capture and compare channels
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int n = 0; n < NCH; n++) ch[n] <= CH_RESET;
      compare_o <= '0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (!channel_direction_select[n]) begin
          if (rise[n]) ch[n] <= main_cnt;
        end else begin
          if (wr_lo && idx == 8'(IDX_CH0 + 2 * n)) ch[n][7:0] <= wdat;
          if (wr_hi && idx == 8'(IDX_CH0 + 2 * n)) ch[n][15:8] <= wb_req_i.dat[15:8];
          if (main_tick && main_cnt == ch[n]) compare_o[n] <= ~compare_o[n];
        end
      end
    end
  end

  // Holding registers for channels 0-3 and the 8-bit accumulators
  assign force_capture_latch = wr_lo & (idx == IDX_DC_CTL) & wdat[BIT_FORCE_CAPTURE_LATCH];
  assign latch_evt = capture_latch_mode
                   & (force_capture_latch | dc_underflow_evt);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int k = 0; k < 4; k++) begin
        hold_ch[k] <= CH_RESET;
        hold_acc[k] <= '0;
      end
    end else if (latch_evt) begin
      for (int k = 0; k < 4; k++) begin
        hold_ch[k] <= ch[k];
        hold_acc[k] <= acc_count[k];
      end
    end
  end

  // Accumulator flags; a set in the clearing cycle wins
  assign fast_clr_a = fast_flag_clear & acc
                    & (idx == IDX_CNT3 || idx == IDX_CNT2 || idx == IDX_ACC_A_WORD);
  assign fast_clr_b = fast_flag_clear & acc
                    & (idx == IDX_CNT1 || idx == IDX_CNT0 || idx == IDX_ACC_B_WORD);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accum_a_overflow_flag <= 1'b0;
      accum_input_edge_flag <= 1'b0;
      accum_b_overflow_flag <= 1'b0;
    end else begin
      if (acc_wrap[3]) begin
        accum_a_overflow_flag <= 1'b1;
      end else if (fast_clr_a || (wr_lo && idx == IDX_ACC_A_FLG && wdat[BIT_OVF])) begin
        accum_a_overflow_flag <= 1'b0;
      end
      if (accum_a_system_enable && accum_pin_edge) begin
        accum_input_edge_flag <= 1'b1;
      end else if (fast_clr_a || (wr_lo && idx == IDX_ACC_A_FLG && wdat[BIT_EDGE])) begin
        accum_input_edge_flag <= 1'b0;
      end
      if (accum_b_system_enable && acc_wrap[1]) begin
        accum_b_overflow_flag <= 1'b1;
      end else if (fast_clr_b || (wr_lo && idx == IDX_ACC_B_FLG && wdat[BIT_OVF])) begin
        accum_b_overflow_flag <= 1'b0;
      end
    end
  end

  // Down-counter control bits; latch and load bits are strobes only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      downcount_irq_enable <= 1'b0;
      reload_mode <= 1'b0;
      load_readback_select <= 1'b0;
      downcounter_enable <= 1'b0;
      dc_presc_sel <= 2'b00;
    end else if (wr_lo && idx == IDX_DC_CTL) begin
      downcount_irq_enable <= wdat[BIT_DOWNCOUNT_IRQ_ENABLE];
      reload_mode <= wdat[BIT_RELOAD_MODE];
      load_readback_select <= wdat[BIT_LOAD_READBACK_SELECT];
      downcounter_enable <= wdat[BIT_DOWNCOUNTER_ENABLE];
      dc_presc_sel <= wdat[1:0];
    end
  end

  // Down-counter strobes
  assign dc_count_write = wr_word & (idx == IDX_DC_COUNT);
  assign force_count_load = wr_lo & (idx == IDX_DC_CTL) & wdat[BIT_FORCE_COUNT_LOAD]
                          & downcounter_enable;
  assign dc_presc_tick = dc_presc_cnt == DC_TERM[dc_active_sel];
  assign dc_underflow_evt = downcounter_enable & ~dc_count_write & ~force_count_load
                          & dc_presc_tick & (downcount_count_register == 16'h0001);

  // Load register takes every count write
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dc_load <= DC_PRESET;
    end else if (dc_count_write) begin
      dc_load <= wb_req_i.dat[15:0];
    end
  end

  // Down-counter with its prescaler
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      downcount_count_register <= DC_PRESET;
      dc_presc_cnt <= 4'h0;
      dc_active_sel <= 2'b00;
    end else if (!downcounter_enable) begin
      downcount_count_register <= DC_PRESET;
      dc_presc_cnt <= 4'h0;
    end else if (dc_count_write) begin
      downcount_count_register <= wb_req_i.dat[15:0];
      dc_presc_cnt <= 4'h0;
      dc_active_sel <= dc_presc_sel;
    end else if (force_count_load) begin
      downcount_count_register <= dc_load;
      dc_presc_cnt <= 4'h0;
      dc_active_sel <= dc_presc_sel;
    end else if (dc_presc_tick) begin
      dc_presc_cnt <= 4'h0;
      if (downcount_count_register == 16'h0001 && reload_mode) begin
        downcount_count_register <= dc_load;
        dc_active_sel <= dc_presc_sel;
      end else if (downcount_count_register != 16'h0000) begin
        downcount_count_register <= downcount_count_register - 1'b1;
      end
    end else begin
      dc_presc_cnt <= dc_presc_cnt + 1'b1;
    end
  end

  // Underflow flag; a set in the clearing cycle wins
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      downcount_underflow_flag <= 1'b0;
    end else if (dc_underflow_evt) begin
      downcount_underflow_flag <= 1'b1;
    end else if ((wr_lo && idx == IDX_DC_FLG && wdat[BIT_UNDER])
                 || (fast_flag_clear && acc && idx == IDX_DC_COUNT)) begin
      downcount_underflow_flag <= 1'b0;
    end
  end

  // Interrupt requests, registered
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accum_a_irq_o <= 1'b0;
      accum_b_irq_o <= 1'b0;
      downcount_irq_o <= 1'b0;
    end else begin
      accum_a_irq_o <= (accum_a_overflow_flag & acc_a_ctl[BIT_OVI])
                     | (accum_input_edge_flag & acc_a_ctl[BIT_PAI]);
      accum_b_irq_o <= accum_b_overflow_flag & acc_b_ctl[BIT_OVI];
      downcount_irq_o <= downcount_underflow_flag & downcount_irq_enable;
    end
  end

  // Read data mux; unmapped indices read zero
  always_comb begin
    rdata = '0;
    for (int n = 0; n < NCH; n++) begin
      if (idx == 8'(IDX_CH0 + 2 * n)) rdata[15:0] = ch[n];
    end
    for (int k = 0; k < 4; k++) begin
      if (idx == 8'(IDX_HOLD_CH0 + k)) rdata[15:0] = hold_ch[k];
      if (idx == 8'(IDX_HOLD_ACC0 + k)) rdata[7:0] = hold_acc[k];
    end
    case (idx)
      IDX_DIR: rdata[NCH-1:0] = channel_direction_select;
      IDX_TCNT: rdata[15:0] = main_cnt;
      IDX_TIMER_CTL: rdata[7:0] = timer_ctl;
      IDX_ACC_A_CTL: rdata[7:0] = acc_a_ctl;
      IDX_ACC_A_FLG: rdata[1:0] = {accum_a_overflow_flag, accum_input_edge_flag};
      IDX_CNT3: rdata[7:0] = acc_count[3];
      IDX_CNT2: rdata[7:0] = acc_count[2];
      IDX_CNT1: rdata[7:0] = acc_count[1];
      IDX_CNT0: rdata[7:0] = acc_count[0];
      IDX_ACC_A_WORD: rdata[15:0] = {acc_count[3], acc_count[2]};
      IDX_ACC_B_WORD: rdata[15:0] = {acc_count[1], acc_count[0]};
      IDX_DC_CTL: rdata[7:0] = {downcount_irq_enable, reload_mode, load_readback_select,
                                2'b00, downcounter_enable, dc_presc_sel};
      IDX_DC_FLG: rdata[BIT_UNDER] = downcount_underflow_flag;
      IDX_ACC_EN: rdata[7:0] = acc_en;
      IDX_IC_SYS: rdata[7:0] = ic_sys;
      IDX_ACC_B_CTL: rdata[7:0] = acc_b_ctl;
      IDX_ACC_B_FLG: rdata[BIT_OVF] = accum_b_overflow_flag;
      IDX_DC_COUNT: rdata[15:0] = load_readback_select ? dc_load
                                                       : downcount_count_register;
      default: ;
    endcase
  end

  // Wishbone answer: ack one cycle after the request, dropped after one cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req && !wb_ack_o) wb_dat_o <= rdata;
    end
  end

endmodule

// [shared/pmt_pkg.sv]
package pmt_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned IDX_W = 8;
  localparam logic [7:0] IDX_DIR = 8'h80;
  localparam logic [7:0] IDX_TCNT = 8'h84;
  localparam logic [7:0] IDX_TIMER_CTL = 8'h86;
  localparam logic [7:0] IDX_CH0 = 8'h90;
  localparam logic [7:0] IDX_ACC_A_CTL = 8'hA0;
  localparam logic [7:0] IDX_ACC_A_FLG = 8'hA1;
  localparam logic [7:0] IDX_CNT3 = 8'hA2;
  localparam logic [7:0] IDX_CNT2 = 8'hA3;
  localparam logic [7:0] IDX_CNT1 = 8'hA4;
  localparam logic [7:0] IDX_CNT0 = 8'hA5;
  localparam logic [7:0] IDX_DC_CTL = 8'hA6;
  localparam logic [7:0] IDX_DC_FLG = 8'hA7;
  localparam logic [7:0] IDX_ACC_EN = 8'hA8;
  localparam logic [7:0] IDX_IC_SYS = 8'hAB;
  localparam logic [7:0] IDX_ACC_B_CTL = 8'hB0;
  localparam logic [7:0] IDX_ACC_B_FLG = 8'hB1;
  localparam logic [7:0] IDX_DC_COUNT = 8'hB6;
  localparam logic [7:0] IDX_ACC_A_WORD = 8'hC0;
  localparam logic [7:0] IDX_ACC_B_WORD = 8'hC2;
  localparam logic [7:0] IDX_HOLD_CH0 = 8'hD0;
  localparam logic [7:0] IDX_HOLD_ACC0 = 8'hD4;

  // Field positions
  localparam int unsigned BIT_TEN = 7;
  localparam int unsigned BIT_FFC = 4;
  localparam int unsigned BIT_ACCUM_A_SYSTEM_ENABLE = 6;
  localparam int unsigned BIT_ACCUM_MODE_SELECT = 5;
  localparam int unsigned BIT_ACCUM_EDGE_SELECT = 4;
  localparam int unsigned BIT_COUNTER_CLOCK_SELECT_HI = 3;
  localparam int unsigned BIT_COUNTER_CLOCK_SELECT_LO = 2;
  localparam int unsigned BIT_OVI = 1;
  localparam int unsigned BIT_PAI = 0;
  localparam int unsigned BIT_OVF = 1;
  localparam int unsigned BIT_EDGE = 0;
  localparam int unsigned BIT_ACCUM_B_SYSTEM_ENABLE = 6;
  localparam int unsigned BIT_DOWNCOUNT_IRQ_ENABLE = 7;
  localparam int unsigned BIT_RELOAD_MODE = 6;
  localparam int unsigned BIT_LOAD_READBACK_SELECT = 5;
  localparam int unsigned BIT_FORCE_CAPTURE_LATCH = 4;
  localparam int unsigned BIT_FORCE_COUNT_LOAD = 3;
  localparam int unsigned BIT_DOWNCOUNTER_ENABLE = 2;
  localparam int unsigned BIT_UNDER = 7;
  localparam int unsigned BIT_CAPTURE_BUFFER_ENABLE = 2;
  localparam int unsigned BIT_LATCH_OR_QUEUE_SELECT = 1;

  // Writable masks; other bits read as zero
  localparam logic [7:0] TIMER_CTL_MASK = 8'h90;
  localparam logic [7:0] ACC_B_CTL_MASK = 8'h42;
  localparam logic [7:0] IC_SYS_MASK = 8'h06;
  localparam logic [7:0] ACC_EN_MASK = 8'h0F;

  // Reset and preset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [15:0] CH_RESET = 16'h0000;
  localparam logic [15:0] DC_PRESET = 16'hFFFF;
  localparam logic [5:0] DIV64_RESET = 6'h00;

  // Down-counter prescaler terminal counts for divide by 1, 4, 8, 16
  localparam logic [3:0] DC_TERM [4] = '{4'h0, 4'h3, 4'h7, 4'hF};

  typedef enum logic [1:0] {
    PMT_CS_PRESCALER = 2'b00,
    PMT_CS_ACCUM = 2'b01,
    PMT_CS_DIV256 = 2'b10,
    PMT_CS_DIV65536 = 2'b11
  } pmt_clk_sel_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [IDX_W+1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pmt_wb_req_t;

endpackage

// [hw/pmt_accum8.sv]
`timescale 1ns/100ps
module pmt_accum8 #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_data_i,
  input wire logic inc_i,
  output logic [W-1:0] count_o,
  output logic wrap_o
);

  // Clear beats load, load beats increment
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_o <= '0;
    end else if (clear_i) begin
      count_o <= '0;
    end else if (load_i) begin
      count_o <= load_data_i;
    end else if (inc_i) begin
      count_o <= count_o + 1'b1;
    end
  end

  // Wrap from all ones to zero, only when the increment really lands
  assign wrap_o = inc_i & (&count_o) & ~clear_i & ~load_i;

endmodule

// [test/pmt_timer_asserts.sv]
`timescale 1ns/100ps
module pmt_timer_asserts
  import pmt_pkg::*;
#(
  parameter int NCH = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire pmt_wb_req_t wb_req_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NCH-1:0] timer_pin_i,
  input wire logic [NCH-1:0] compare_o,
  input wire logic accum_a_irq_o,
  input wire logic accum_b_irq_o,
  input wire logic downcount_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Decoded bus events at the ack edge
  wire [7:0] idx = wb_req_i.adr[9:2];
  wire wr = wb_ack_o && wb_req_i.we && wb_req_i.sel[0];
  wire rd = wb_ack_o && !wb_req_i.we;
  // Bus handshake
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_delay: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_req_i.stb))
    else $error("ack without request");
  // Strobe bits and spare flag bits read as zero
  a_strobe_zero: assert property (
    rd && idx == IDX_DC_CTL |-> wb_dat_o[4:3] == 2'h0) else $error("strobe bit read 1");
  a_flag_spare: assert property (
    rd && idx == IDX_ACC_A_FLG |-> wb_dat_o[7:2] == 6'h00) else $error("spare flag bit");
  // Cleared enables silence the request lines
  a_irq_a_mask: assert property (
    wr && idx == IDX_ACC_A_CTL && wb_req_i.dat[1:0] == 2'h0 |-> ##2 !accum_a_irq_o)
    else $error("acc a irq while masked");
  a_irq_b_mask: assert property (
    wr && idx == IDX_ACC_B_CTL && !wb_req_i.dat[1] |-> ##2 !accum_b_irq_o)
    else $error("acc b irq while masked");
  a_dc_mask: assert property (
    wr && idx == IDX_DC_CTL && !wb_req_i.dat[7] |-> ##2 !downcount_irq_o)
    else $error("down count irq while masked");
  c_dc_irq: cover property (downcount_irq_o);
  c_a_irq: cover property (accum_a_irq_o);
  c_dc_load: cover property (wr && idx == IDX_DC_COUNT);
endmodule

// [test/pmt_pin_drv.sv]
`timescale 1ns/100ps
module pmt_pin_drv (
  input wire logic clk_i,
  output logic [7:0] pin_o
);
  initial pin_o = 8'h00;
  // Pulses on one pin, each level held gap cycles, then settles low
  task automatic pulse(input int ch, input int n, input int gap);
    repeat (n) begin
      pin_o[ch] <= 1'b1;
      repeat (gap) @(posedge clk_i);
      pin_o[ch] <= 1'b0;
      repeat (gap) @(posedge clk_i);
    end
  endtask
endmodule

// [test/pmt_timer_tb.sv]
`timescale 1ns/100ps
module pmt_timer_tb;
  import pmt_pkg::*;
  logic clk_i, reset_n_i, irq_a, irq_b, irq_dc, ack;
  logic [7:0] pin, cmp;
  logic [31:0] dat, q, t1;
  pmt_wb_req_t req;
  int num_errors = 0;
  int n_tests = 0;
  pmt_timer #(.NCH(8)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_req_i(req),
    .wb_dat_o(dat), .wb_ack_o(ack), .timer_pin_i(pin), .compare_o(cmp),
    .accum_a_irq_o(irq_a), .accum_b_irq_o(irq_b), .downcount_irq_o(irq_dc));
  pmt_pin_drv pin_u (.clk_i(clk_i), .pin_o(pin));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                    output logic [31:0] r);
    int t;
    t = 0;
    req <= '{1'b1, 1'b1, w, {a, 2'h0}, 4'h3, {16'h0000, d}};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) num_errors++;
    r = dat;
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 16'h0000, q);
    chk(s, e, q);
  endtask
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
  initial begin
    req = '0;
    reset_n_i = 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    // Reset values and channel write protection
    rdc("dc preset", IDX_DC_COUNT, 32'hFFFF);
    wr(IDX_CH0, 16'h1234);
    rdc("ch0 capture", IDX_CH0, 32'h0);
    wr(IDX_DIR, 16'h0001);
    wr(IDX_CH0, 16'h1234);
    rdc("ch0 compare", IDX_CH0, 32'h1234);
    // Accumulator B wrap
    wr(IDX_ACC_B_CTL, 16'h0042);
    wr(IDX_ACC_B_WORD, 16'hFFFF);
    pin_u.pulse(0, 1, 4);
    chk("irq b", 32'h1, irq_b);
    wr(IDX_ACC_B_CTL, 16'h0000);
    // Event counting, both polarities, main timer off
    wr(IDX_ACC_A_CTL, 16'h0040);
    pin_u.pulse(7, 3, 4);
    rdc("acc a fall", IDX_ACC_A_WORD, 32'h3);
    rdc("edge flag", IDX_ACC_A_FLG, 32'h1);
    wr(IDX_ACC_A_CTL, 16'h0051);
    pin_u.pulse(7, 2, 20);
    rdc("acc a rise", IDX_ACC_A_WORD, 32'h5);
    chk("irq a", 32'h1, irq_a);
    wr(IDX_ACC_A_FLG, 16'h0001);
    @(posedge clk_i);
    chk("irq a clr", 32'h0, irq_a);
    // Word write at the top, wrap, then fast clear
    wr(IDX_ACC_A_WORD, 16'hFFFF);
    pin_u.pulse(7, 1, 4);
    rdc("wrap flags", IDX_ACC_A_FLG, 32'h3);
    wr(IDX_TIMER_CTL, 16'h0010);
    rdc("acc a low", IDX_CNT2, 32'h0);
    rdc("fast clr", IDX_ACC_A_FLG, 32'h0);
    // Gated mode without and with the main timer
    wr(IDX_TIMER_CTL, 16'h0000);
    wr(IDX_ACC_A_CTL, 16'h0060);
    pin_u.pulse(7, 1, 200);
    rdc("gate off", IDX_ACC_A_WORD, 32'h0);
    rdc("gate flag", IDX_ACC_A_FLG, 32'h1);
    wr(IDX_TIMER_CTL, 16'h0080);
    pin_u.pulse(7, 1, 640);
    wb(1'b0, IDX_ACC_A_WORD, 16'h0000, q);
    chk("gate on", 32'h1, q inside {[9:11]});
    // Counter source follows the select only with accumulator A on
    wr(IDX_ACC_A_CTL, 16'h0044);
    wb(1'b0, IDX_TCNT, 16'h0000, t1);
    rdc("tcnt held", IDX_TCNT, t1);
    wr(IDX_ACC_A_CTL, 16'h0004);
    wb(1'b0, IDX_TCNT, 16'h0000, t1);
    wb(1'b0, IDX_TCNT, 16'h0000, q);
    chk("tcnt runs", 32'h1, q != t1);
    // Single-shot down count, underflow interrupt, readback
    wr(IDX_DC_CTL, 16'h0084);
    wr(IDX_DC_COUNT, 16'h0010);
    repeat (40) @(posedge clk_i);
    rdc("dc stop", IDX_DC_COUNT, 32'h0);
    chk("dc irq", 32'h1, irq_dc);
    wr(IDX_DC_FLG, 16'h0080);
    @(posedge clk_i);
    chk("dc irq clr", 32'h0, irq_dc);
    wr(IDX_DC_CTL, 16'h00B4);
    rdc("dc load", IDX_DC_COUNT, 32'h10);
    rdc("dc ctl", IDX_DC_CTL, 32'hA4);
    rdc("no latch", IDX_HOLD_CH0, 32'h0);
    wr(IDX_DC_CTL, 16'h0008);
    rdc("dc off", IDX_DC_COUNT, 32'hFFFF);
    // Forced latch copies channel 0 and accumulator two, then clears it
    wr(IDX_IC_SYS, 16'h0006);
    wb(1'b0, IDX_CNT2, 16'h0000, t1);
    wr(IDX_DC_CTL, 16'h0010);
    rdc("hold ch0", IDX_HOLD_CH0, 32'h1234);
    rdc("hold acc2", IDX_HOLD_ACC0 + 8'h02, t1);
    rdc("acc2 clr", IDX_CNT2, 32'h0);
    // Reload mode set while stopped; divide by 4 makes three counts take twelve clocks
    wr(IDX_DC_CTL, 16'h0041);
    wr(IDX_DC_CTL, 16'h0045);
    wr(IDX_DC_COUNT, 16'h0003);
    repeat (5) @(posedge clk_i);
    rdc("dc presc", IDX_DC_FLG, 32'h0);
    repeat (5) @(posedge clk_i);
    rdc("dc reload flag", IDX_DC_FLG, 32'h80);
    rdc("dc reload", IDX_DC_COUNT, 32'h2);
    // Compare toggles its output; capture takes the running count
    wb(1'b0, IDX_TCNT, 16'h0000, t1);
    wr(IDX_CH0, t1[15:0] + 16'h0028);
    repeat (50) @(posedge clk_i);
    chk("cmp0", 32'h1, cmp[0]);
    wb(1'b0, IDX_TCNT, 16'h0000, t1);
    pin_u.pulse(1, 1, 2);
    wb(1'b0, IDX_CH0 + 8'h02, 16'h0000, q);
    chk("ch1 capture", 32'h1, q > t1 && q < t1 + 32'h10);
    give_verdict();
  end
endmodule
bind pmt_timer pmt_timer_asserts #(.NCH(NCH)) chk_u (.clk_i, .reset_n_i, .wb_req_i,
  .wb_dat_o, .wb_ack_o, .timer_pin_i, .compare_o, .accum_a_irq_o, .accum_b_irq_o,
  .downcount_irq_o);
